//--- logic/odia_params.svh
// Constants for the operand decode and indirect addressing block.
// Assumes inclusion by odia_pkg.sv and odia_decode.sv only.
`ifndef ODIA_PARAMS_SVH
`define ODIA_PARAMS_SVH

// Instruction cycle timing
`define ODIA_OSC_PER_CYC   4

// Instruction word layout
`define ODIA_IW            12
`define ODIA_CLASS_HI      11
`define ODIA_CLASS_LO      10
`define ODIA_DEST_POS      5
`define ODIA_BIT_HI        7
`define ODIA_BIT_LO        5
`define ODIA_FILE_HI       4
`define ODIA_FILE_LO       0
`define ODIA_LIT8_HI       7
`define ODIA_LIT9_HI       8
`define ODIA_BIT_TEST_POS  9

// Opcode patterns, only the listed bits are compared
`define ODIA_CLS_BYTE      2'h0
`define ODIA_CLS_BIT       2'h1
`define ODIA_JUMP_PAT      3'h5
`define ODIA_CALL_PAT      4'h9
`define ODIA_RETL_PAT      4'h8
`define ODIA_NOP_WORD      12'h000

// File addresses within a bank
`define ODIA_INDIRECT_ADDR 5'h00
`define ODIA_PCL_ADDR      5'h02
`define ODIA_PTR_ADDR      5'h04

// Bus register offsets and reset values
`define ODIA_OFS_PTR       8'h00
`define ODIA_OFS_BANK      8'h04
`define ODIA_OFS_STATE     8'h08
`define ODIA_PTR_RST       7'h00
`define ODIA_BANK_RST      2'h0

`endif

//--- logic/odia_pkg.sv
// Types shared by the operand decode block and its phase sequencer.
// Assumes odia_params.svh is on the include path.
`include "odia_params.svh"

package odia_pkg;

  // Instruction cycle phases, Gray coded along the loop
  typedef enum logic [1:0]
  {
    ODIA_Q1 = 2'h0,
    ODIA_Q2 = 2'h1,
    ODIA_Q3 = 2'h3,
    ODIA_Q4 = 2'h2
  } odia_phase_e;

  // Instruction format classes
  typedef enum logic [1:0]
  {
    ODIA_BYTE = 2'h0,
    ODIA_BITOP = 2'h1,
    ODIA_LIT = 2'h2
  } odia_class_e;

  // Decoded fields of one instruction word
  typedef struct packed
  {
    odia_class_e cls;
    logic        dest_file;
    logic [2:0]  bit_sel;
    logic [4:0]  file;
    logic [8:0]  literal;
    logic        jump;
    logic        pc_write;
  } odia_dec_s;

endpackage : odia_pkg

//--- logic/odia_phase.sv
// Four-phase instruction cycle sequencer.
// Assumes each CORE_CLK edge is one oscillator period.
`timescale 1ns/1ps
`default_nettype none

module odia_phase
  import odia_pkg::*;
(
  input  wire logic  clk,      // Oscillator clock
  input  wire logic  rst_n,    // Asynchronous reset, active low
  output var odia_phase_e phase    // Current phase
);

  odia_phase_e phase_q;
  odia_phase_e phase_d;

  // Next phase around the loop
  always_comb
  begin
    case (phase_q)
      ODIA_Q1: phase_d = ODIA_Q2;
      ODIA_Q2: phase_d = ODIA_Q3;
      ODIA_Q3: phase_d = ODIA_Q4;
      ODIA_Q4: phase_d = ODIA_Q1;
      default: phase_d = ODIA_Q1;
    endcase
  end

  // Phase register, one step per oscillator period
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      phase_q <= ODIA_Q1;
    else
      phase_q <= phase_d;
  end

  assign phase = phase_q;

  sequence odia_loop_s;
    phase_q == ODIA_Q1 ##1 phase_q == ODIA_Q2 ##1
    phase_q == ODIA_Q3 ##1 phase_q == ODIA_Q4;
  endsequence

  phase_loop_a: assert property (@(posedge clk) disable iff (!rst_n)
    phase_q == ODIA_Q1 |-> odia_loop_s ##1 phase_q == ODIA_Q1)
    else $error("Instruction cycle is not four periods");

endmodule : odia_phase

`default_nettype wire

//--- logic/odia_decode.sv
// Operand decode and indirect data addressing for an 8-bit core.
// Assumes program memory presents the next word on INSTR_IN by Q4,
// the data file answers a read in the same clock that DF_RD is high, and the ALU
// gives RESULT and SKIP_REQ by Q4 of the same instruction cycle.
//
// Notes on behaviour
// - Indirect slot reaches the register the pointer names; slot holds nothing.
// - Indirect read while pointer is zero returns zero.
// - Indirect write to the slot itself stores nothing.
// - Pointer is 5 bits unbanked, 7 bits banked.
// - Low five pointer bits select addresses 0 to 31 in the bank.
// - Unbanked parts read pointer bits six and five as ones.
// - Banked parts use pointer bits six and five as bank number.
// - Instruction is a 12-bit word split into opcode and operands.
// - Byte operand selects one of 32 file registers of the bank.
// - Destination bit zero goes to accumulator, one to the file.
// - Bit operand picks the bit of the 8-bit file register.
// - Literal and control words carry an 8 or 9 bit constant.
// - One cycle normally, two on true test or program counter change.
// - One instruction cycle is four oscillator periods.
// - Don't-care instruction bits never affect decoding.
// - Indirect slot sits at file address zero.
// - Jump carries a 9-bit target, others 8 bits.
//
// The APB interface to the registers and the register offsets were left to the implementer.
`include "odia_params.svh"
`timescale 1ns/1ps
`default_nettype none

module odia_decode
  import odia_pkg::*;
#(
  parameter bit BANKED = 1'b1        // Banked variant with 7-bit pointer
)
(
  input  wire logic        CORE_CLK,    // Oscillator clock
  input  wire logic        RESETN,      // Asynchronous reset, active low
  input  wire logic        PSEL,        // APB select
  input  wire logic        PENABLE,     // APB access phase
  input  wire logic        PWRITE,      // APB write
  input  wire logic [7:0]  PADDR,       // APB byte address
  input  wire logic [31:0] PWDATA,      // APB write data
  output logic      [31:0] PRDATA,      // APB read data
  output logic             PREADY,      // APB ready
  output logic             PSLVERR,     // APB error on unmapped
  input  wire logic [11:0] INSTR_IN,    // Prefetched word
  input  wire logic [7:0]  RESULT,      // ALU result for write back
  input  wire logic        SKIP_REQ,    // Conditional test is true
  input  wire logic [7:0]  DF_RDATA,    // Data file read data
  output logic             PM_NEXT,     // Advance program fetch
  output logic      [6:0]  DF_ADDR,     // Data file address
  output logic             DF_RD,       // Data file read strobe
  output logic             DF_WR,       // Data file write strobe
  output logic      [7:0]  DF_WDATA,    // Data file write data
  output logic      [7:0]  OPERAND,     // File operand value
  output logic      [1:0]  OP_CLASS,    // Instruction class
  output logic             DEST_FILE,   // Result goes to file
  output logic      [2:0]  BIT_SEL,     // Bit position
  output logic      [8:0]  LITERAL,     // Immediate constant
  output logic             TWO_CYCLE,   // Extra no-op cycle running
  output logic      [1:0]  PHASE        // Phase, registered one clock behind
);

  localparam int PTR_W = BANKED ? 7 : 5;

  odia_phase_e phase;
  odia_dec_s   dec;
  logic [11:0] ir_q;
  logic [6:0]  ptr_q;
  logic [1:0]  bank_q;
  logic        flush_q;
  logic        indirect;
  logic        self_ref;
  logic        uses_file;
  logic        writes_file;
  logic [4:0]  eff_addr;
  logic [1:0]  eff_bank;
  logic [1:0]  ptr_bank;
  logic [7:0]  ptr_rd;
  logic        ptr_hit;
  logic        pc_change;
  logic        setup;
  logic        bus_acc;
  logic        wr_ptr_bus;
  logic [31:0] rd_d;
  logic        err_d;

  // Phase sequencer
  odia_phase u_phase
  (
    .clk   (CORE_CLK),
    .rst_n (RESETN),
    .phase (phase)
  );

  // Field extraction; only defined bits take part
  always_comb
  begin
    dec = '0;
    dec.file = ir_q[`ODIA_FILE_HI:`ODIA_FILE_LO];
    dec.bit_sel = ir_q[`ODIA_BIT_HI:`ODIA_BIT_LO];
    dec.jump = ir_q[11:9] == `ODIA_JUMP_PAT;
    if (ir_q[`ODIA_CLASS_HI:`ODIA_CLASS_LO] == `ODIA_CLS_BYTE)
    begin
      dec.cls = ODIA_BYTE;
      dec.dest_file = ir_q[`ODIA_DEST_POS];
    end
    else if (ir_q[`ODIA_CLASS_HI:`ODIA_CLASS_LO] == `ODIA_CLS_BIT)
    begin
      dec.cls = ODIA_BITOP;
      dec.dest_file = !ir_q[`ODIA_BIT_TEST_POS];
    end
    else
    begin
      dec.cls = ODIA_LIT;
    end
    // Jump target is 9 bits, every other constant 8
    if (dec.jump)
      dec.literal = ir_q[`ODIA_LIT9_HI:0];
    else
      dec.literal = {1'b0, ir_q[`ODIA_LIT8_HI:0]};
    dec.pc_write = dec.jump || ir_q[11:8] == `ODIA_CALL_PAT
                   || ir_q[11:8] == `ODIA_RETL_PAT;
  end

  // Effective data address through the pointer when needed
  always_comb
  begin
    indirect = dec.file == `ODIA_INDIRECT_ADDR;
    ptr_bank = BANKED ? ptr_q[6:5] : 2'h0;
    eff_addr = indirect ? ptr_q[4:0] : dec.file;
    eff_bank = indirect ? ptr_bank : bank_q;
    self_ref = indirect && ptr_q[4:0] == `ODIA_INDIRECT_ADDR;
    uses_file = dec.cls != ODIA_LIT && ir_q != `ODIA_NOP_WORD;
    writes_file = uses_file && dec.dest_file;
    ptr_hit = eff_addr == `ODIA_PTR_ADDR;
    pc_change = dec.pc_write || (writes_file
                && eff_addr == `ODIA_PCL_ADDR);
  end

  // Pointer read view; missing bank bits read as ones
  generate
    if (BANKED)
    begin : g_banked
      assign ptr_rd = {1'b0, ptr_q};
    end
    else
    begin : g_flat
      assign ptr_rd = {1'b0, 2'h3, ptr_q[4:0]};
    end
  endgenerate

  // Pointer register: instruction write back beats the bus
  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
      ptr_q <= `ODIA_PTR_RST;
    else if (phase == ODIA_Q4 && writes_file && ptr_hit && !self_ref)
      ptr_q <= 7'(RESULT[PTR_W-1:0]);
    else if (wr_ptr_bus)
      ptr_q <= 7'(PWDATA[PTR_W-1:0]);
  end

  // Direct bank selection, set by software
  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
      bank_q <= `ODIA_BANK_RST;
    else if (bus_acc && PWRITE && PADDR == `ODIA_OFS_BANK)
      bank_q <= BANKED ? PWDATA[1:0] : 2'h0;
  end

  // Instruction register loads at Q4; flushed word becomes no-op
  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ir_q <= `ODIA_NOP_WORD;
      flush_q <= 1'b0;
    end
    else if (phase == ODIA_Q4)
    begin
      flush_q <= pc_change || SKIP_REQ;
      ir_q <= (pc_change || SKIP_REQ) ? `ODIA_NOP_WORD : INSTR_IN;
    end
  end

  // Decoded field outputs, refreshed at Q1
  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      OP_CLASS <= 2'h0;
      DEST_FILE <= 1'b0;
      BIT_SEL <= 3'h0;
      LITERAL <= 9'h000;
      TWO_CYCLE <= 1'b0;
    end
    else if (phase == ODIA_Q1)
    begin
      OP_CLASS <= dec.cls;
      DEST_FILE <= writes_file;
      BIT_SEL <= dec.bit_sel;
      LITERAL <= dec.literal;
      TWO_CYCLE <= flush_q;
    end
  end

  // Data file read at Q2, address stands through Q4
  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      DF_ADDR <= 7'h00;
      DF_RD <= 1'b0;
    end
    else
    begin
      DF_RD <= phase == ODIA_Q2 && uses_file && !self_ref;
      if (phase == ODIA_Q2)
        DF_ADDR <= {eff_bank, eff_addr};
    end
  end

  // Operand capture at Q3; slot aimed at itself gives zero
  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
      OPERAND <= 8'h00;
    else if (phase == ODIA_Q3)
      OPERAND <= self_ref ? 8'h00 : (ptr_hit ? ptr_rd : DF_RDATA);
  end

  // Write back at Q4; self target and pointer slot skip the file
  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      DF_WR <= 1'b0;
      DF_WDATA <= 8'h00;
      PM_NEXT <= 1'b0;
    end
    else
    begin
      DF_WR <= phase == ODIA_Q4 && writes_file && !self_ref
               && !ptr_hit;
      if (phase == ODIA_Q4)
        DF_WDATA <= RESULT;
      PM_NEXT <= phase == ODIA_Q4;
    end
  end

  // Phase output
  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
      PHASE <= 2'h0;
    else
      PHASE <= phase;
  end

  // APB decode, no wait state; read data is registered from a flop in the setup cycle
  assign setup = PSEL && !PENABLE;
  // Writes land only at the access edge that sees PREADY high
  assign bus_acc = PSEL && PENABLE && PREADY;
  assign wr_ptr_bus = bus_acc && PWRITE && PADDR == `ODIA_OFS_PTR;

  always_comb
  begin
    rd_d = 32'h0000_0000;
    err_d = 1'b0;
    case (PADDR)
      `ODIA_OFS_PTR: rd_d = {24'h000000, ptr_rd};
      `ODIA_OFS_BANK: rd_d = {30'h0000_0000, bank_q};
      `ODIA_OFS_STATE: rd_d = {16'h0000, ir_q, flush_q, TWO_CYCLE,
                               phase};
      default: err_d = 1'b1;
    endcase
  end

  // APB answer registers
  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end
    else
    begin
      PREADY <= setup;
      PSLVERR <= setup && err_d;
      if (setup && !PWRITE)
        PRDATA <= rd_d;
      else if (setup)
        PRDATA <= 32'h0000_0000;
    end
  end

  // Checks
  self_rd_zero_a: assert property (@(posedge CORE_CLK)
    disable iff (!RESETN)
    phase == ODIA_Q3 && self_ref |=> OPERAND == 8'h00)
    else $error("Self indirect read not zero");

  self_wr_none_a: assert property (@(posedge CORE_CLK)
    disable iff (!RESETN)
    phase == ODIA_Q4 && self_ref && writes_file && !wr_ptr_bus |=>
      !DF_WR && $stable(ptr_q))
    else $error("Self indirect write stored data");

  indir_addr_a: assert property (@(posedge CORE_CLK)
    disable iff (!RESETN)
    phase == ODIA_Q2 && indirect |=>
      DF_ADDR[4:0] == $past(ptr_q[4:0]))
    else $error("Indirect address not from pointer");

  indir_bank_a: assert property (@(posedge CORE_CLK)
    disable iff (!RESETN)
    phase == ODIA_Q2 && indirect && BANKED |=>
      DF_ADDR[6:5] == $past(ptr_q[6:5]))
    else $error("Indirect bank not from pointer");

  flat_ones_a: assert property (@(posedge CORE_CLK)
    disable iff (!RESETN)
    !BANKED && setup && !PWRITE && PADDR == `ODIA_OFS_PTR |=>
      PRDATA[6:5] == 2'h3)
    else $error("Unbanked pointer bits not ones");

  acc_dest_a: assert property (@(posedge CORE_CLK)
    disable iff (!RESETN)
    phase == ODIA_Q4 && dec.cls == ODIA_BYTE
      && !ir_q[`ODIA_DEST_POS] |=> !DF_WR)
    else $error("Accumulator result written to file");

  sequence flush_seq_s;
    ir_q == `ODIA_NOP_WORD ##4 TWO_CYCLE;
  endsequence

  flush_nop_a: assert property (@(posedge CORE_CLK)
    disable iff (!RESETN)
    phase == ODIA_Q4 && pc_change |=> flush_seq_s)
    else $error("Prefetched word not discarded");

  jump_lit_a: assert property (@(posedge CORE_CLK)
    disable iff (!RESETN)
    phase == ODIA_Q1 && dec.jump |=> LITERAL == $past(ir_q[8:0]))
    else $error("Jump target not 9 bits");

  lit8_a: assert property (@(posedge CORE_CLK)
    disable iff (!RESETN)
    phase == ODIA_Q1 && dec.cls == ODIA_LIT && !dec.jump |=>
      LITERAL == {1'b0, $past(ir_q[7:0])})
    else $error("Literal not 8 bits");

endmodule : odia_decode

`default_nettype wire

//--- verif/odia_dfile.sv
// Data register file model: four banks of 32 bytes behind the decoder.
// Assumes DF_ADDR is settled while the read strobe is high.
`timescale 1ns/1ps
`default_nettype none

module odia_dfile
(
  input  wire logic       clk,    // Core clock
  input  wire logic [6:0] addr,   // Bank and file address
  input  wire logic       rd,     // Read strobe
  input  wire logic       wr,     // Write strobe
  input  wire logic [7:0] wdata,  // Write data
  output logic      [7:0] rdata   // Read data
);
  logic [7:0] mem [0:127];
  logic [7:0] junk_q = 8'hA5;

  // Data only while read, else a pattern that changes every cycle
  assign rdata = rd ? mem[addr] : junk_q;

  // Store on write strobe; bench may preload the array
  always @(posedge clk)
  begin
    junk_q <= ~junk_q;
    if (wr)
      mem[addr] <= wdata;
  end
endmodule : odia_dfile

`default_nettype wire

//--- verif/operand_decode_indirect_addr_tb.sv
// Bench for the operand decoder: APB, instruction stream, data file.
// Assumes odia_pkg, odia_decode and odia_dfile are compiled first.
`timescale 1ns/1ps
`default_nettype none

module operand_decode_indirect_addr_tb;
  import odia_pkg::*;

`define CHK(g, e) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); \
    end \
  end

  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, psel2 = 1'b0;
  logic        pen = 1'b0, pwr = 1'b0, skip = 1'b0;
  logic        rd_d = 1'b0, pm_d = 1'b0;
  logic [7:0]  paddr = 8'h00, result = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, prdata2;
  logic [11:0] instr = 12'h000;
  logic        pready, pready2, pslverr, pslverr2, pm_next, df_rd, df_wr;
  logic        dest_file, two_cycle;
  logic [6:0]  df_addr, ptr = 7'h00;
  logic [7:0]  df_wdata, df_rdata, operand, sh [0:127];
  logic [1:0]  op_class, phase, dbank = 2'h0;
  logic [2:0]  bit_sel;
  logic [8:0]  literal;
  logic [32:0] aq [$], wq [$], rq [$], fq [$];
  logic [12:0] prog [$];
  int          error_cnt = 0, checks_done = 0, seed = 32'h8DC7;
  wire logic [11:0] fv = (op_class == 2'h0) ? {11'h0, dest_file} :
                         (op_class == 2'h1) ? {9'h0, bit_sel} :
                         {3'h0, literal};

  // Clock
  initial
    forever #5 clk = ~clk;

  odia_decode #(.BANKED(1'b1)) odia_decode_inst (
    .CORE_CLK(clk), .RESETN(rst_n), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .INSTR_IN(instr),
    .RESULT(result), .SKIP_REQ(skip), .DF_RDATA(df_rdata),
    .PM_NEXT(pm_next), .DF_ADDR(df_addr), .DF_RD(df_rd), .DF_WR(df_wr),
    .DF_WDATA(df_wdata), .OPERAND(operand), .OP_CLASS(op_class),
    .DEST_FILE(dest_file), .BIT_SEL(bit_sel), .LITERAL(literal),
    .TWO_CYCLE(two_cycle), .PHASE(phase));

  // Unbanked variant, register bus only
  odia_decode #(.BANKED(1'b0)) odia_decode_inst2 (
    .CORE_CLK(clk), .RESETN(rst_n), .PSEL(psel2), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata2),
    .PREADY(pready2), .PSLVERR(pslverr2), .INSTR_IN(instr),
    .RESULT(result), .SKIP_REQ(skip), .DF_RDATA(df_rdata), .PM_NEXT(),
    .DF_ADDR(), .DF_RD(), .DF_WR(), .DF_WDATA(), .OPERAND(),
    .OP_CLASS(), .DEST_FILE(), .BIT_SEL(), .LITERAL(), .TWO_CYCLE(),
    .PHASE());

  odia_dfile odia_dfile_inst (
    .clk(clk), .addr(df_addr), .rd(df_rd), .wr(df_wr),
    .wdata(df_wdata), .rdata(df_rdata));

  // Oldest note against observed value; empty queue always mismatches
  task automatic cmp(input logic [32:0] got, ref logic [32:0] q [$]);
    logic [32:0] e;
    begin
      e = (q.size() != 0) ? q.pop_front() : ~got;
      `CHK(got, e)
    end
  endtask : cmp

  // Monitor of read answers, file strobes and decoded fields
  always @(posedge clk)
  begin
    rd_d <= df_rd;
    pm_d <= pm_next;
    if (pen && !pwr && pready)
      cmp({pslverr, prdata}, aq);
    if (pen && !pwr && pready2)
      cmp({pslverr2, prdata2}, aq);
    if (df_wr)
      cmp({18'h0, df_addr, df_wdata}, wq);
    if (rd_d)
      cmp({18'h0, df_addr, operand}, rq);
    if (pm_d && fq.size() != 0)
      cmp({16'h0, phase, op_class, two_cycle, fv}, fq);
  end

  // One APB transfer; u picks the unbanked instance
  task automatic apb(input logic u, input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    int n;
    begin
      n = 0;
      if (!w)
        aq.push_back(e);
      psel   <= !u;
      psel2  <= u;
      pwr    <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do
        @(posedge clk);
      while (!(pready | pready2) && ++n < 20);
      if (!(pready | pready2))
        error_cnt++;
      psel  <= 1'b0;
      psel2 <= 1'b0;
      pen   <= 1'b0;
      @(posedge clk);
    end
  endtask : apb

  // Expected class, cycle flag and operand field of one word
  function automatic logic [32:0] fields(input logic [11:0] x);
    logic [1:0]  c;
    logic [11:0] v;
    begin
      c = x[11] ? 2'h2 : {1'b0, x[10]};
      v = x[11] ? (x[11:9] == 3'h5 ? {3'h0, x[8:0]} : {4'h0, x[7:0]})
        : x[10] ? {9'h0, x[7:5]} : {11'h0, x[5]};
      fields = {18'h0, c, 1'b0, v};
    end
  endfunction : fields

  // Feed prog word by word on each fetch; bit 12 asks for a skip
  task automatic run();
    logic [11:0] x;
    logic [6:0]  a;
    logic [7:0]  r, pr;
    logic        fl, dr, ps, live;
    int          n;
    begin
      fl = 1'b0;
      pr = 8'h00;
      ps = 1'b0;
      foreach (prog[i])
      begin
        n = 0;
        do
          @(posedge clk);
        while (!pm_next && ++n < 50);
        if (!pm_next)
          error_cnt++;
        // Word shown next was fed earlier; note it unless already pending
        if (i == 0 && fq.size() == 0)
          fq.push_back(33'h0);
        x = prog[i][11:0];
        r = $random(seed);
        instr  <= x;
        result <= pr;
        skip   <= ps;
        dr = fl;
        fl = !dr && (x[11:9] == 3'h5 || x[11:9] == 3'h4 || prog[i][12]);
        pr = r;
        ps = !dr && prog[i][12];
        if (dr)
          fq.push_back({20'h0, 1'b1, 12'h000});
        else
          fq.push_back(fields(x));
        a = (x[4:0] == 5'h00) ? ptr : {dbank, x[4:0]};
        live = !dr && x != 12'h000 && !x[11] && a[4:0] != 5'h00;
        if (live)
          rq.push_back({18'h0, a, sh[a]});
        if (live && (x[10] ? !x[9] : x[5]))
        begin
          wq.push_back({18'h0, a, r});
          sh[a] = r;
        end
      end
    end
  endtask : run

  // Verdict and end of run
  task automatic end_sim();
    begin
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask : end_sim

  // Watchdog
  initial
  begin
    #100000;
    error_cnt++;
    end_sim();
  end

  // Main sequence
  initial
  begin
    for (int i = 0; i < 128; i++)
    begin
      sh[i] = $random(seed);
      odia_dfile_inst.mem[i] = sh[i];
    end
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    apb(0, 0, 8'h08, 0, 33'h0);
    apb(0, 0, 8'h00, 0, 33'h0);
    apb(0, 0, 8'h04, 0, 33'h0);
    apb(0, 0, 8'h0C, 0, {1'b1, 32'h0});
    apb(0, 1, 8'h00, 32'hFF, 0);
    apb(0, 0, 8'h00, 0, {1'b0, 32'h7F});
    apb(1, 1, 8'h00, 32'h00, 0);
    apb(1, 0, 8'h00, 0, {1'b0, 32'h60});
    ptr   = 7'h28;
    dbank = 2'h2;
    apb(0, 1, 8'h00, {25'h0, ptr}, 0);
    apb(0, 1, 8'h04, {30'h0, dbank}, 0);
    prog = '{13'h01E9, 13'h01C0, 13'h01E0, 13'h05FF, 13'h166A, 13'h01EA,
             13'h0CA5, 13'h0B55, 13'h01EB, 13'h093C, 13'h01E9, 13'h0881,
             13'h01E8, 13'h040C, 13'h0000, 13'h0000};
    run();
    foreach (prog[i])
      prog[i] = 13'h0000;
    for (int k = 0; k < 4; k++)
    begin
      ptr = (k == 3) ? 7'h7F : {k[1:0], 5'h00};
      apb(0, 1, 8'h00, {25'h0, ptr}, 0);
      prog = '{13'h01E0, 13'h01C0, 13'h0000, 13'h0000};
      run();
    end
    repeat (16) @(posedge clk);
    if (aq.size() + wq.size() + rq.size() + fq.size() != 0)
      error_cnt++;
    end_sim();
  end
endmodule : operand_decode_indirect_addr_tb

`default_nettype wire
